// ==== uhc_cmd_ctrl.sv ====
// Command-register control of a USB 2.0 host controller with its AXI4-Lite slave.
// Assumes a free-running 100 MHz ref_clk; schedule engines and ports sit outside.
// Summary of operation
// R01: Park mode bits 11:8 of the command register read zero and ignore writes.
// R02: The light reset bit 7 reads zero and ignores writes.
// R03: A doorbell write sets the async-advance status flag once cached async state is evicted.
// R04: The doorbell bit clears only after the async-advance status flag has been set.
// R05: With its enable set, the async-advance flag raises the interrupt at the next threshold boundary.
// R06: Software does not ring the doorbell while the async schedule is inactive.
// R07: Async schedule enable off skips the async schedule; on fetches from the async list pointer.
// R08: Periodic enable off skips the periodic schedule; on fetches via the periodic list pointer.
// R09: Frame list size reads zero, is unwritable, and the list always has 1024 entries.
// R10: Writing one to the soft reset bit resets internal state and aborts USB activity without bus reset.
// R11: Soft reset restores operational and port registers and returns port ownership to companions.
// R12: The soft reset bit self-clears when reset completes; writing zero does not shorten it.
// R13: Software only requests soft reset while the halted flag is one.
// R14: Soft reset leaves configuration and capability registers unchanged.
// R15: Soft reset takes every port out of test mode.
// R16: After soft reset software reprograms the operational state.
// R17: The halted flag sets only after the current transaction ends following a stop request.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module uhc_cmd_ctrl (
    input  wire logic                 ref_clk,          // 100 MHz clock
    input  wire logic                 reset_n,          // Chip reset, async, active low
    input  wire logic [7:0]           s_axi_awaddr,     // Write address
    input  wire logic                 s_axi_awvalid,    // Write address valid
    output logic                      s_axi_awready,    // Write address ready
    input  wire logic [31:0]          s_axi_wdata,      // Write data
    input  wire logic [3:0]           s_axi_wstrb,      // Write byte strobes
    input  wire logic                 s_axi_wvalid,     // Write data valid
    output logic                      s_axi_wready,     // Write data ready
    output logic [1:0]                s_axi_bresp,      // Write response
    output logic                      s_axi_bvalid,     // Write response valid
    input  wire logic                 s_axi_bready,     // Write response ready
    input  wire logic [7:0]           s_axi_araddr,     // Read address
    input  wire logic                 s_axi_arvalid,    // Read address valid
    output logic                      s_axi_arready,    // Read address ready
    output logic [31:0]               s_axi_rdata,      // Read data
    output logic [1:0]                s_axi_rresp,      // Read response
    output logic                      s_axi_rvalid,     // Read data valid
    input  wire logic                 s_axi_rready,     // Read data ready
    input  wire logic                 evict_done,       // Engine reports async cache evicted
    input  wire logic                 transaction_idle, // No USB transaction in progress
    output uhc_pkg::uhc_sched_s       sched,            // Schedule enables and pointers
    output logic                      run,              // Run request to engines
    output logic                      evict_req,        // Ask engine to evict async cache
    output logic                      ctrl_reset,       // Internal reset pulse level to engines
    output logic                      port_owner_companion, // Ports handed to companions
    output logic                      port_test_exit,   // Leave any port test mode
    output logic                      irq               // Async advance interrupt
);
    // Register state
    logic [31:0] async_ptr, periodic_ptr;
    logic [7:0]  thresh;
    logic        run_bit, async_en, periodic_en, doorbell, adv_sts, adv_ien, halted;
    logic        adv_pending, irq_q;
    uhc_pkg::uhc_rst_e rst_state;
    logic [4:0]  rst_cnt;
    logic [13:0] uf_cnt;
    logic [7:0]  uf_tick_cnt;

    // Write and read channel capture
    logic        aw_full, w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        ar_pend;
    logic [7:0]  ar_addr;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !ar_pend && !s_axi_rvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_full && w_full && !s_axi_bvalid;
    wire [31:0] wd = w_data;
    wire        wb0 = w_strb[0];
    wire wr_cmd  = wr_go && aw_addr == uhc_pkg::CMD_OFFSET;
    wire wr_sts  = wr_go && aw_addr == uhc_pkg::STS_OFFSET;
    wire wr_ien  = wr_go && aw_addr == uhc_pkg::INTEN_OFFSET;
    wire wr_aptr = wr_go && aw_addr == uhc_pkg::ASYNC_PTR_OFFSET;
    wire wr_pptr = wr_go && aw_addr == uhc_pkg::PERIOD_PTR_OFFSET;
    wire wr_thr  = wr_go && aw_addr == uhc_pkg::THRESH_OFFSET;
    wire wr_hit  = wr_cmd | wr_sts | wr_ien | wr_aptr | wr_pptr | wr_thr;
    wire in_reset = rst_state == uhc_pkg::RST_BUSY;
    wire soft_req = wr_cmd && wb0 && wd[uhc_pkg::SOFT_RESET_BIT] && !in_reset; // R10
    wire cmd_wr   = wr_cmd && wb0 && !in_reset;
    wire clr_adv  = wr_sts && wb0 && wd[uhc_pkg::ADVANCE_STS_BIT];
    wire set_adv  = doorbell && evict_done;                                    // R03

    // Read data, hardwired fields read zero
    wire [31:0] cmd_rd = {8'h00, thresh, 8'h00,                               // R01
                          1'b0,                                                // R02
                          doorbell, async_en, periodic_en,
                          uhc_pkg::FRAME_LIST_CODE,                            // R09
                          in_reset, run_bit};                                  // R12
    wire [31:0] sts_rd = ({31'h0, halted} << uhc_pkg::HALTED_STS_BIT) |
                         ({31'h0, adv_sts} << uhc_pkg::ADVANCE_STS_BIT);      // R17
    wire [31:0] ien_rd = {31'h0, adv_ien} << uhc_pkg::ADVANCE_IEN_BIT;
    wire        rd_hit = ar_addr == uhc_pkg::CMD_OFFSET || ar_addr == uhc_pkg::STS_OFFSET ||
                         ar_addr == uhc_pkg::INTEN_OFFSET || ar_addr == uhc_pkg::ASYNC_PTR_OFFSET ||
                         ar_addr == uhc_pkg::PERIOD_PTR_OFFSET || ar_addr == uhc_pkg::THRESH_OFFSET;
    wire [31:0] rd_mux = ar_addr == uhc_pkg::CMD_OFFSET        ? cmd_rd :
                         ar_addr == uhc_pkg::STS_OFFSET        ? sts_rd :
                         ar_addr == uhc_pkg::INTEN_OFFSET      ? ien_rd :
                         ar_addr == uhc_pkg::ASYNC_PTR_OFFSET  ? async_ptr :
                         ar_addr == uhc_pkg::PERIOD_PTR_OFFSET ? periodic_ptr :
                         ar_addr == uhc_pkg::THRESH_OFFSET     ? {24'h0, thresh} : 32'h0;

    // Micro-frame tick and threshold boundary
    wire uf_tick  = uf_cnt == 14'(uhc_pkg::UFRAME_CYCLES - 1);
    wire boundary = uf_tick && (uf_tick_cnt + 8'h01 >= thresh);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= uhc_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? uhc_pkg::RESP_OKAY : uhc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ar_pend <= 1'b0;
            ar_addr <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= uhc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_pend <= 1'b1;
                ar_addr <= s_axi_araddr;
            end
            if (ar_pend) begin
                ar_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? uhc_pkg::RESP_OKAY : uhc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Soft reset sequencer; holds until count ends, a zero write cannot cut it short
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_state <= uhc_pkg::RST_IDLE;
            rst_cnt   <= 5'h00;
        end else begin
            unique case (rst_state)
                uhc_pkg::RST_IDLE: begin
                    if (soft_req) begin                                        // R10
                        rst_state <= uhc_pkg::RST_BUSY;
                        rst_cnt   <= 5'(uhc_pkg::RESET_CYCLES_NUM - 1);
                    end
                end
                uhc_pkg::RST_BUSY: begin
                    if (rst_cnt == 5'h00) begin
                        rst_state <= uhc_pkg::RST_IDLE;                        // R12
                    end else begin
                        rst_cnt <= rst_cnt - 5'h01;
                    end
                end
                default: rst_state <= uhc_pkg::RST_IDLE;
            endcase
        end
    end

    // Operational registers; restored by soft reset, capability values live elsewhere
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_bit      <= 1'b0;
            async_en     <= 1'b0;
            periodic_en  <= 1'b0;
            async_ptr    <= 32'h0;
            periodic_ptr <= 32'h0;
            thresh       <= uhc_pkg::THRESH_RESET;
            adv_ien      <= 1'b0;
        end else if (in_reset) begin                                           // R11 R14
            run_bit      <= 1'b0;
            async_en     <= 1'b0;
            periodic_en  <= 1'b0;
            async_ptr    <= 32'h0;
            periodic_ptr <= 32'h0;
            thresh       <= uhc_pkg::THRESH_RESET;
            adv_ien      <= 1'b0;
        end else begin
            if (cmd_wr && !soft_req) begin
                run_bit     <= wd[uhc_pkg::RUN_BIT];
                async_en    <= wd[uhc_pkg::ASYNC_EN_BIT];                      // R07
                periodic_en <= wd[uhc_pkg::PERIODIC_EN_BIT];                   // R08
            end
            if (wr_cmd && w_strb[2] && !soft_req) begin
                thresh <= wd[23:16];
            end
            if (wr_aptr) begin
                async_ptr <= wd;
            end
            if (wr_pptr) begin
                periodic_ptr <= wd;
            end
            if (wr_thr && wb0) begin
                thresh <= wd[7:0];
            end
            if (wr_ien && wb0) begin
                adv_ien <= wd[uhc_pkg::ADVANCE_IEN_BIT];
            end
        end
    end

    // Doorbell, status flag, halted flag; hardware set wins over software clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            doorbell <= 1'b0;
            adv_sts  <= 1'b0;
            halted   <= 1'b1;
        end else if (in_reset) begin
            doorbell <= 1'b0;
            adv_sts  <= 1'b0;
            halted   <= 1'b1;
        end else begin
            if (set_adv) begin
                doorbell <= 1'b0;                                              // R04
            end else if (cmd_wr && !soft_req && wd[uhc_pkg::DOORBELL_BIT]) begin
                doorbell <= 1'b1;                                              // R06
            end
            if (set_adv) begin
                adv_sts <= 1'b1;                                               // R03
            end else if (clr_adv) begin
                adv_sts <= 1'b0;
            end
            if (run_bit) begin
                halted <= 1'b0;
            end else if (transaction_idle) begin
                halted <= 1'b1;                                                // R17
            end
        end
    end

    // Interrupt waits for the threshold boundary
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            uf_cnt      <= 14'h0000;
            uf_tick_cnt <= 8'h00;
            adv_pending <= 1'b0;
            irq_q       <= 1'b0;
        end else if (in_reset) begin
            uf_cnt      <= 14'h0000;
            uf_tick_cnt <= 8'h00;
            adv_pending <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            uf_cnt <= uf_tick ? 14'h0000 : uf_cnt + 14'h0001;
            if (boundary) begin
                uf_tick_cnt <= 8'h00;
            end else if (uf_tick) begin
                uf_tick_cnt <= uf_tick_cnt + 8'h01;
            end
            if (set_adv) begin
                adv_pending <= 1'b1;
            end else if (boundary) begin
                adv_pending <= 1'b0;
            end
            if (!adv_sts || !adv_ien) begin
                irq_q <= 1'b0;
            end else if (boundary && adv_pending) begin
                irq_q <= 1'b1;                                                 // R05
            end
        end
    end

    assign sched.async_en       = async_en && !in_reset;                      // R07
    assign sched.periodic_en    = periodic_en && !in_reset;                   // R08
    assign sched.async_ptr      = async_ptr;
    assign sched.periodic_ptr   = periodic_ptr;
    assign run                  = run_bit;
    assign evict_req            = doorbell;
    assign ctrl_reset           = in_reset;                                    // R10
    assign port_owner_companion = in_reset;                                    // R11
    assign port_test_exit       = in_reset;                                    // R15
    assign irq                  = irq_q;
endmodule

// ==== uhc_pkg.sv ====
// Package for the host command control block: register map, field positions, timing.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.
package uhc_pkg;
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  CMD_OFFSET        = 8'h00;
    localparam logic [7:0]  STS_OFFSET        = 8'h04;
    localparam logic [7:0]  INTEN_OFFSET      = 8'h08;
    localparam logic [7:0]  ASYNC_PTR_OFFSET  = 8'h0C;
    localparam logic [7:0]  PERIOD_PTR_OFFSET = 8'h10;
    localparam logic [7:0]  THRESH_OFFSET     = 8'h14;
    localparam int          RUN_BIT           = 0;
    localparam int          SOFT_RESET_BIT    = 1;
    localparam int          PERIODIC_EN_BIT   = 4;
    localparam int          ASYNC_EN_BIT      = 5;
    localparam int          DOORBELL_BIT      = 6;
    localparam int          ADVANCE_STS_BIT   = 5;
    localparam int          HALTED_STS_BIT    = 12;
    localparam int          ADVANCE_IEN_BIT   = 5;
    localparam logic [1:0]  FRAME_LIST_CODE   = 2'h0;
    localparam int          FRAME_LIST_ENTRIES = 1024;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          UFRAME_NS         = 125000;
    localparam int          UFRAME_CYCLES     = UFRAME_NS / CLK_PERIOD_NS;
    localparam int          EVICT_CYCLES_NUM  = 4;
    localparam int          RESET_CYCLES_NUM  = 16;
    localparam logic [7:0]  THRESH_RESET      = 8'h08;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef struct packed {
        logic        async_en;
        logic        periodic_en;
        logic [31:0] async_ptr;
        logic [31:0] periodic_ptr;
    } uhc_sched_s;

    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_BUSY  = 2'b01
    } uhc_rst_e;
endpackage

// ==== uhc_cmd_ctrl_chk.sv ====
// Concurrent checks for the host command control block, bound to its top module.
// Assumes the single ref_clk domain and the asynchronous active-low reset_n.
`timescale 1ns/10ps
module uhc_cmd_ctrl_chk (
    input wire logic               ref_clk,              // Clock
    input wire logic               reset_n,              // Reset, active low
    input wire logic [7:0]         s_axi_araddr,         // Read address
    input wire logic               s_axi_arvalid,        // Read address valid
    input wire logic               s_axi_arready,        // Read address ready
    input wire logic [31:0]        s_axi_rdata,          // Read data
    input wire logic               s_axi_rvalid,         // Read data valid
    input wire logic               evict_done,           // Eviction finished
    input wire uhc_pkg::uhc_sched_s sched,               // Schedule enables and pointers
    input wire logic               evict_req,            // Doorbell pending
    input wire logic               ctrl_reset,           // Soft reset active
    input wire logic               port_owner_companion, // Ports to companions
    input wire logic               port_test_exit,       // Leave port test mode
    input wire logic               irq                   // Async advance interrupt
);
    logic [7:0] rd_addr;
    logic [5:0] rst_cnt;
    logic       adv_seen;
    // Only one read is open at a time, so the last taken address names the data
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_addr <= 8'h00;
            rst_cnt <= 6'h00;
            adv_seen <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
            rst_cnt <= ctrl_reset ? rst_cnt + 6'h01 : 6'h00;
            // An interrupt may only follow an eviction seen since the last soft reset
            if (ctrl_reset) begin
                adv_seen <= 1'b0;
            end else if (evict_req && evict_done) begin
                adv_seen <= 1'b1;
            end
        end
    end
    wire cmd_rd = s_axi_rvalid && (rd_addr == uhc_pkg::CMD_OFFSET);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_park_zero:  assert property (cmd_rd |-> s_axi_rdata[11:8] == 4'h0) else $error("park bits not zero");
    a_light_zero: assert property (cmd_rd |-> !s_axi_rdata[7]) else $error("light reset bit not zero");
    a_fls_zero:   assert property (cmd_rd |-> s_axi_rdata[3:2] == 2'h0) else $error("frame list size not zero");
    a_door_hold:  assert property (evict_req && !evict_done && !ctrl_reset |=> evict_req)
        else $error("doorbell dropped before status flag set");
    a_door_clear: assert property (evict_req && evict_done |=> !evict_req) else $error("doorbell not cleared");
    a_irq_after:  assert property ($rose(irq) |-> adv_seen) else $error("interrupt before advance flag");
    a_reset_len:  assert property ($fell(ctrl_reset) |-> rst_cnt == 6'(uhc_pkg::RESET_CYCLES_NUM))
        else $error("soft reset length wrong");
    a_reset_side: assert property (ctrl_reset |-> port_owner_companion && port_test_exit && !sched.async_en
        && !sched.periodic_en) else $error("soft reset side effects missing");
    c_door:  cover property (evict_req && evict_done);
    c_irq:   cover property ($rose(irq));
    c_reset: cover property ($fell(ctrl_reset));
endmodule
bind uhc_cmd_ctrl uhc_cmd_ctrl_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .evict_done(evict_done), .sched(sched), .evict_req(evict_req),
    .ctrl_reset(ctrl_reset), .port_owner_companion(port_owner_companion), .port_test_exit(port_test_exit), .irq(irq));

// ==== test_usb2_host_command_control.sv ====
// Self-checking bench for the host command control block over its AXI4-Lite slave.
// Assumes the engine side is played by the bench through evict_done and transaction_idle.
`timescale 1ns/10ps
module test_usb2_host_command_control;
    logic        ref_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, evict_done, transaction_idle;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, run, evict_req, ctrl_reset, owner, test_exit, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata;
    uhc_pkg::uhc_sched_s sched;
    int          num_errors, n_tests, cyc;
    uhc_cmd_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evict_done(evict_done),
        .transaction_idle(transaction_idle), .sched(sched), .run(run), .evict_req(evict_req),
        .ctrl_reset(ctrl_reset), .port_owner_companion(owner), .port_test_exit(test_exit), .irq(irq));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every task starts and ends just after a rising edge; inputs move by non-blocking assignment
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1'b1;
                resp = bresp;
            end
        end
    endtask
    task automatic rdr(input logic [7:0] a);
        logic done;
        done = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1'b1;
                rd = rdata;
                resp = rresp;
            end
        end
    endtask
    task automatic t_defaults();
        rdr(uhc_pkg::CMD_OFFSET); chk(rd, 32'h0008_0000);
        rdr(uhc_pkg::STS_OFFSET); chk(rd, 32'h0000_1000);
        chk({sched.async_en, sched.periodic_en}, 32'h0);
        $display("test defaults done");
    endtask
    task automatic t_fields();
        wr(uhc_pkg::CMD_OFFSET, 32'h0008_0FBC, 4'hF); chk(resp, uhc_pkg::RESP_OKAY);
        rdr(uhc_pkg::CMD_OFFSET); chk(rd, 32'h0008_0030);
        chk({sched.async_en, sched.periodic_en}, 32'h3);
        wr(uhc_pkg::ASYNC_PTR_OFFSET, 32'hA5A5_5A40, 4'hF); chk(sched.async_ptr, 32'hA5A5_5A40);
        wr(uhc_pkg::PERIOD_PTR_OFFSET, 32'h1234_5000, 4'hF); chk(sched.periodic_ptr, 32'h1234_5000);
        wr(8'h40, 32'hFFFF_FFFF, 4'hF); chk(resp, uhc_pkg::RESP_SLVERR);
        rdr(8'h40); chk(resp, uhc_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        $display("test fields done");
    endtask
    task automatic t_doorbell();
        int n;
        wr(uhc_pkg::INTEN_OFFSET, 32'h0000_0020, 4'hF);
        wr(uhc_pkg::THRESH_OFFSET, 32'h0000_0001, 4'hF);
        wr(uhc_pkg::CMD_OFFSET, 32'h0001_0060, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk(evict_req, 32'h1);
        rdr(uhc_pkg::STS_OFFSET); chk(rd & 32'h20, 32'h0);
        evict_done <= 1'b1;
        @(posedge ref_clk);
        evict_done <= 1'b0;
        @(posedge ref_clk);
        rdr(uhc_pkg::STS_OFFSET); chk(rd & 32'h20, 32'h20);
        rdr(uhc_pkg::CMD_OFFSET); chk(rd & 32'h40, 32'h0);
        chk(irq, 32'h0);
        n = 0;
        while (!irq && n < 13000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(irq, 32'h1);
        wr(uhc_pkg::STS_OFFSET, 32'h0000_0020, 4'h1);
        @(posedge ref_clk);
        chk(irq, 32'h0);
        $display("test doorbell done");
    endtask
    task automatic t_halt();
        transaction_idle <= 1'b0;
        wr(uhc_pkg::CMD_OFFSET, 32'h0001_0021, 4'hF);
        chk(run, 32'h1);
        rdr(uhc_pkg::STS_OFFSET); chk(rd & 32'h1000, 32'h0);
        wr(uhc_pkg::CMD_OFFSET, 32'h0001_0020, 4'hF);
        repeat (4) @(posedge ref_clk);
        rdr(uhc_pkg::STS_OFFSET); chk(rd & 32'h1000, 32'h0);
        transaction_idle <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdr(uhc_pkg::STS_OFFSET); chk(rd & 32'h1000, 32'h1000);
        $display("test halt done");
    endtask
    task automatic t_soft_reset();
        wr(uhc_pkg::CMD_OFFSET, 32'h0001_0032, 4'hF);
        rdr(uhc_pkg::CMD_OFFSET); chk(rd & 32'h2, 32'h2);
        chk({ctrl_reset, owner, test_exit}, 32'h7);
        wr(uhc_pkg::CMD_OFFSET, 32'h0000_0000, 4'hF);
        chk(ctrl_reset, 32'h1);
        repeat (20) @(posedge ref_clk);
        chk(ctrl_reset, 32'h0);
        rdr(uhc_pkg::CMD_OFFSET); chk(rd, 32'h0008_0000);
        chk(sched.async_ptr, 32'h0);
        wr(uhc_pkg::CMD_OFFSET, 32'h0008_0030, 4'hF);
        chk({sched.async_en, sched.periodic_en}, 32'h3);
        $display("test soft reset done");
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        num_errors = 0; n_tests = 0; cyc = 0; reset_n = 1'b0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; evict_done = 1'b0; transaction_idle = 1'b1;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        t_defaults();
        t_fields();
        t_doorbell();
        t_halt();
        t_soft_reset();
        conclude();
    end
endmodule
